// File: keyboard_defines.vh
// Constants for the function keyboard encoder and its register map.
`ifndef KEYBOARD_DEFINES_VH
`define KEYBOARD_DEFINES_VH

// ------------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_RESP 8'h08
`define ADDR_LAMPS 8'h0C

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define CTRL_READ_BIT 0
`define CTRL_GATE_BIT 1
`define STAT_VALID_BIT 0
`define STAT_REQ_BIT 1
`define STAT_ATTN_BIT 2
`define STAT_GATE_BIT 3
`define STAT_CODE_LSB 8
`define STAT_OVL_LSB 16
`define SOURCE_BIT 1

// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define CTRL_RESET 2'b00
`define LAMPS_RESET 32'h0000_0000
`define CLK_HZ 20000000
`define SETTLE_MS 36
`define SETTLE_CYCLES ((`CLK_HZ / 1000) * `SETTLE_MS)

`endif

// File: key_settle_timer.v
// Settling timer that fires once a key has stayed down for the delay.
`timescale 1ns/10ps
module key_settle_timer #(
    parameter SETTLE_CYCLES = 720000
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Control
    input wire key_down,
    output reg settled
);
    reg [19:0] count_r;

    // Any bounce restarts the count, so contacts must hold steady.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= 20'h0_0000;
            settled <= 1'b0;
        end else if (!key_down) begin
            count_r <= 20'h0_0000;
            settled <= 1'b0;
        end else if (count_r < SETTLE_CYCLES[19:0] - 20'h0_0001) begin
            count_r <= count_r + 20'h0_0001;
            settled <= 1'b0;
        end else begin
            settled <= 1'b1;
        end
    end
endmodule // key_settle_timer

// File: key_encoder.v
// Combines 32 key lines by OR into a five-bit binary key number.
`timescale 1ns/10ps
module key_encoder (
    // Key lines
    input wire [31:0] keys,
    // Result
    output reg [4:0] code,
    output reg any_down
);
    integer i;

    always @* begin
        code = 5'h00;
        any_down = 1'b0;
        for (i = 0; i < 32; i = i + 1) begin
            if (keys[i]) begin
                code = code | i[4:0];
                any_down = 1'b1;
            end
        end
    end
endmodule // key_encoder

// File: function_keyboard_encoder.v
// Function keyboard encoder with an AHB-Lite register slave.
`timescale 1ns/10ps
`include "keyboard_defines.vh"
module function_keyboard_encoder #(
    parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Keyboard
    input wire [31:0] keys,
    input wire [7:0] overlay_switches,
    output wire [31:0] key_lamps,
    // Channel side
    output wire attention_interrupt,
    output wire keyboard_input_request,
    output reg [7:0] inbound_bus,
    output reg inbound_valid
);
    // ------------------------------------------------------------------
    // Key capture
    // ------------------------------------------------------------------
    wire [4:0] raw_code;
    wire any_down;
    wire settled;
    reg [4:0] function_key_code_r;
    reg key_code_valid_r;
    reg [7:0] overlay_r;
    reg key_code_release;

    key_encoder u_enc (
        .keys(keys),
        .code(raw_code),
        .any_down(any_down)
    );

    key_settle_timer #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .key_down(any_down),
        .settled(settled)
    );

    // Release wins over a fresh capture; a held key is captured again
    // only after its timer restarts, which needs the key to go up.
    reg settled_seen_r;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            function_key_code_r <= 5'h00;
            key_code_valid_r <= 1'b0;
            overlay_r <= 8'h00;
            settled_seen_r <= 1'b0;
        end else begin
            settled_seen_r <= settled;
            if (key_code_release) begin
                function_key_code_r <= 5'h00;
                key_code_valid_r <= 1'b0;
            end else if (settled && !settled_seen_r &&
                         !key_code_valid_r) begin
                function_key_code_r <= raw_code;
                key_code_valid_r <= 1'b1;
                overlay_r <= overlay_switches;
            end
        end
    end

    assign attention_interrupt = key_code_valid_r;
    assign keyboard_input_request = key_code_valid_r;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    reg [31:0] lamps_r;
    reg gate_latch_r;
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    reg rd_req;
    reg [1:0] byte_idx_r;
    reg sending_r;

    wire take = hsel && hready && htrans[1];
    wire [7:0] word_addr = {haddr[7:2], 2'b00};

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign key_lamps = lamps_r;

    always @* begin
        rd_req = wr_pend_r && (wr_addr_r == `ADDR_CTRL) &&
                 hwdata[`CTRL_READ_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
            lamps_r <= `LAMPS_RESET;
            gate_latch_r <= 1'b0;
        end else begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= word_addr;
            hrdata <= 32'h0000_0000;
            if (take && !hwrite) begin
                case (word_addr)
                    `ADDR_STATUS: hrdata <= {8'h00, overlay_r,
                        3'b000, function_key_code_r, 4'h0,
                        gate_latch_r, attention_interrupt,
                        keyboard_input_request, key_code_valid_r};
                    `ADDR_RESP: hrdata <= {24'h00_0000, inbound_bus};
                    `ADDR_LAMPS: hrdata <= lamps_r;
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
            if (wr_pend_r && wr_addr_r == `ADDR_LAMPS) begin
                lamps_r <= hwdata;
            end
            if (wr_pend_r && wr_addr_r == `ADDR_CTRL) begin
                gate_latch_r <= hwdata[`CTRL_GATE_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read-operator-inputs response
    // ------------------------------------------------------------------
    // The read command is ignored while no key code is valid, so a
    // stray command cannot release an empty latch set.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sending_r <= 1'b0;
            byte_idx_r <= 2'b00;
            inbound_bus <= 8'h00;
            inbound_valid <= 1'b0;
            key_code_release <= 1'b0;
        end else begin
            key_code_release <= 1'b0;
            inbound_valid <= 1'b0;
            inbound_bus <= 8'h00;
            if (!sending_r) begin
                if (rd_req && key_code_valid_r) begin
                    sending_r <= 1'b1;
                    byte_idx_r <= 2'b00;
                end
            end else if (gate_latch_r) begin
                inbound_valid <= 1'b1;
                case (byte_idx_r)
                    2'b00: inbound_bus <= 8'h01 << `SOURCE_BIT;
                    2'b01: inbound_bus <= {3'b000,
                        function_key_code_r};
                    default: inbound_bus <= overlay_r;
                endcase
                if (byte_idx_r == 2'b10) begin
                    sending_r <= 1'b0;
                    key_code_release <= 1'b1;
                end else begin
                    byte_idx_r <= byte_idx_r + 2'b01;
                end
            end
        end
    end
endmodule // function_keyboard_encoder

// File: keyboard_checker.sv
// Port assertions for the function keyboard encoder.
`timescale 1ns/10ps
module keyboard_checker #(
    parameter SETTLE_CYCLES = 20
) (
    // Clock, reset and keyboard
    input wire hclk,
    input wire hresetn,
    input wire [31:0] keys,
    input wire [7:0] overlay_switches,
    // Channel side
    input wire attention_interrupt,
    input wire keyboard_input_request,
    input wire [7:0] inbound_bus,
    input wire inbound_valid
);
    integer held;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // --------------------------------------------------------------
    // Cycles that some key has been held without a break.
    // --------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            held <= 0;
        else if (keys == 32'h0000_0000)
            held <= 0;
        else if (held < SETTLE_CYCLES)
            held <= held + 1;
    end
    property p_req; attention_interrupt == keyboard_input_request; endproperty
    a_req: assert property (p_req) else $error("req");
    property p_settle; $rose(attention_interrupt) |-> held >= SETTLE_CYCLES;
    endproperty
    a_settle: assert property (p_settle) else $error("settle");
    property p_src; $rose(inbound_valid) |-> inbound_bus == 8'h02; endproperty
    a_src: assert property (p_src) else $error("byte0");
    property p_three; $rose(inbound_valid) |-> inbound_valid[*3] ##1 !inbound_valid;
    endproperty
    a_three: assert property (p_three) else $error("count");
    property p_ovl; $rose(inbound_valid) |=> ##1 inbound_bus == overlay_switches;
    endproperty
    a_ovl: assert property (p_ovl) else $error("byte2");
    property p_hold; attention_interrupt && !inbound_valid |=> attention_interrupt;
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_rel; $fell(inbound_valid) |-> ##[0:1] !attention_interrupt;
    endproperty
    a_rel: assert property (p_rel) else $error("release");
    property p_gate; inbound_valid |-> attention_interrupt; endproperty
    a_gate: assert property (p_gate) else $error("gate");
endmodule // keyboard_checker
bind function_keyboard_encoder keyboard_checker #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) keyboard_checker_i (
    .hclk(hclk), .hresetn(hresetn), .keys(keys),
    .overlay_switches(overlay_switches),
    .attention_interrupt(attention_interrupt),
    .keyboard_input_request(keyboard_input_request),
    .inbound_bus(inbound_bus), .inbound_valid(inbound_valid)
);

// File: host_channel_model.sv
// Host channel model that collects the keyboard bytes.
`timescale 1ns/10ps
module host_channel_model (
    // Channel side
    input wire hclk,
    input wire attention_interrupt,
    input wire [7:0] inbound_bus,
    input wire inbound_valid,
    // Bench side
    output wire want_read,
    output reg [23:0] got_r,
    output reg [7:0] got_n
);
    // The host asks for the bytes as soon as attention is up.
    assign want_read = attention_interrupt;
    initial got_r = 24'h00_0000;
    initial got_n = 8'h00;
    always @(posedge hclk) begin
        if (inbound_valid === 1'b1) begin
            got_r <= {got_r[15:0], inbound_bus};
            got_n <= got_n + 8'h01;
        end
    end
endmodule // host_channel_model

// File: function_keyboard_encoder_bench.sv
// Self-checking bench for the function keyboard encoder.
`timescale 1ns/10ps
`include "keyboard_defines.vh"
module function_keyboard_encoder_bench;
    localparam SETTLE = 20;
    reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    reg [1:0] htrans = 2'h0;
    reg [31:0] haddr = 0, hwdata = 0, keys = 0, r, lamps;
    reg [7:0] ovl = 0, code;
    wire hreadyout, hresp, attn, req, ivalid, want_read;
    wire [31:0] hrdata, key_lamps;
    wire [7:0] ibus, got_n;
    wire [23:0] got_r;
    integer err_count = 0, total_checks = 0, i, k, n, sent = 0;
    reg [31:0] case_q [$];
    function_keyboard_encoder #(.SETTLE_CYCLES(SETTLE))
    function_keyboard_encoder_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .keys(keys),
        .overlay_switches(ovl), .key_lamps(key_lamps),
        .attention_interrupt(attn), .keyboard_input_request(req),
        .inbound_bus(ibus), .inbound_valid(ivalid));
    host_channel_model host_channel_model_i (.hclk(hclk),
        .attention_interrupt(attn), .inbound_bus(ibus),
        .inbound_valid(ivalid), .want_read(want_read), .got_r(got_r),
        .got_n(got_n));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (err_count == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Waits for hreadyout (w=0) or for want_read to equal v (w=1).
    task wait_for(input w, input v);
        begin
            n = 0;
            @(posedge hclk);
            while ((w ? want_read : hreadyout) !== v && n < 60) begin
                n = n + 1;
                @(posedge hclk);
            end
            if ((w ? want_read : hreadyout) !== v) begin
                chk(0, 1);
                report_and_stop;
            end
        end
    endtask
    task bus(input w, input [31:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            wait_for(0, 1);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            wait_for(0, 1);
            r = hrdata;
        end
    endtask
    initial begin
        forever #25 hclk = ~hclk;
    end
    initial begin
        void'($urandom(32'h6e56ee74));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        lamps = $urandom;
        bus(1, `ADDR_LAMPS, lamps);
        bus(0, `ADDR_LAMPS, 0);
        chk(r, lamps);
        chk(key_lamps, lamps);
        chk({31'h0, hresp}, 32'h0);
        bus(0, 32'h10, 0);
        chk(r, 0);
        bus(0, `ADDR_STATUS, 0);
        chk(r, 0);
        case_q = '{32'h1, 32'h8000_0000, 32'h0000_0024};
        case_q.push_back((1 << ($urandom % 32)) | (1 << ($urandom % 32)));
        for (k = 0; k < 4; k = k + 1) begin
            ovl <= $urandom;
            keys <= case_q[k];
            code = 0;
            for (i = 0; i < 32; i = i + 1)
                if (case_q[k][i]) code = code | i[7:0];
            wait_for(1, 1);
            bus(0, `ADDR_STATUS, 0);
            chk(r, {8'h0, ovl, 3'h0, code[4:0], k ? 8'h0f : 8'h07});
            keys <= 0;
            @(posedge hclk);
            keys <= 32'h0000_0040;
            repeat (SETTLE + 5) @(posedge hclk);
            keys <= 0;
            bus(0, `ADDR_STATUS, 0);
            chk(r[12:8], code[4:0]);
            if (k == 0) begin
                bus(1, `ADDR_CTRL, 1);
                repeat (8) @(posedge hclk);
                chk(got_n, sent);
            end
            bus(1, `ADDR_CTRL, k ? 3 : 2);
            wait_for(1, 0);
            repeat (2) @(posedge hclk);
            sent = sent + 3;
            chk(got_n, sent[7:0]);
            chk(got_r, {8'h02, 3'h0, code[4:0], ovl});
            bus(0, `ADDR_STATUS, 0);
            chk(r[12:0], 13'h0008);
        end
        report_and_stop;
    end
endmodule // function_keyboard_encoder_bench
